// ==== rtl/pmbaf_frontend.sv ====
// Two-wire management front end with strap address and write gating
`timescale 1ns/1ps
module pmbaf_frontend
    import pmbaf_pkg::*;
#(
    parameter int unsigned TMO_CYC = TIMEOUT_CYC,
    parameter int unsigned REG_CYC = ADDR_REG_CYC,
    parameter logic [6:0] TGT_BASE = TGT_BASE_DEF
)(
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic scl_i,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe,
    input wire logic aux_bias_supply,
    input wire logic module_disabled,
    input wire logic hi_below_uvlo,
    input wire logic [LEVEL_W-1:0] addr_level_mv,
    output logic [6:0] tgt_addr,
    output logic addr_valid,
    output logic [7:0] cmd_code,
    output logic [7:0] wr_data,
    output logic wr_stb,
    output logic rd_req,
    input wire logic [7:0] rd_data,
    output logic bus_busy
);
    localparam int unsigned TW = $clog2(TMO_CYC + 1);

    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (sys_rst);

    pmbaf_strap_if strap ();

    pmbaf_strap_latch #(
        .REG_CYC(REG_CYC),
        .TGT_BASE(TGT_BASE)
    ) u_strap (
        .mclk(mclk),
        .sys_rst(sys_rst),
        .addr_level_mv(addr_level_mv),
        .sp(strap)
    );

    // Pin synchronisers: a change counts once stages two and three agree
    logic [SYN_N-1:0] pin_in, s1_r, s2_r, s3_r, filt_r, filt_nxt, prev_r;
    assign pin_in = {hi_below_uvlo, module_disabled, aux_bias_supply,
        sda_i, scl_i};

    generate
        for (genvar g = 0; g < SYN_N; g++)
        begin : g_filt
            always_comb
            begin
                filt_nxt[g] = (s2_r[g] == s3_r[g]) ? s3_r[g] : filt_r[g];
            end
        end
    endgenerate

    always_ff @(posedge mclk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            s1_r <= SYN_RST;
            s2_r <= SYN_RST;
            s3_r <= SYN_RST;
            filt_r <= SYN_RST;
            prev_r <= SYN_RST;
        end
        else
        begin
            s1_r <= pin_in;
            s2_r <= s1_r;
            s3_r <= s2_r;
            filt_r <= filt_nxt;
            prev_r <= filt_r;
        end
    end

    logic scl_rise, scl_fall, start_c, stop_c, bias, write_ok;
    assign scl_rise = filt_r[SYN_SCL] & ~prev_r[SYN_SCL];
    assign scl_fall = ~filt_r[SYN_SCL] & prev_r[SYN_SCL];
    assign start_c = filt_r[SYN_SCL] & prev_r[SYN_SCL] & prev_r[SYN_SDA]
        & ~filt_r[SYN_SDA];
    assign stop_c = filt_r[SYN_SCL] & prev_r[SYN_SCL] & ~prev_r[SYN_SDA]
        & filt_r[SYN_SDA];
    assign bias = filt_r[SYN_BIAS];

    // Byte engine state
    pmbaf_state_e st_r, st_nxt;
    logic [2:0] bit_r, bit_nxt;
    logic [7:0] sh_r, sh_nxt, cmd_r, cmd_nxt, wd_r, wd_nxt;
    logic [1:0] ph_r, ph_nxt;
    logic rw_r, rw_nxt, oe_r, oe_nxt, ack_r, ack_nxt;
    logic stb_r, stb_nxt, rdq_r, rdq_nxt;

    // Write permission per command class
    always_comb
    begin
        if (cmd_r == CMD_OPERATION)
            write_ok = bias;
        else if (is_limit_cmd(cmd_r))
            write_ok = bias & filt_r[SYN_DIS] & filt_r[SYN_UVLO];
        else
            write_ok = 1'b1;
    end

    // Clock-low timeout counter
    logic [TW-1:0] tmo_r, tmo_nxt;
    logic tmo_hit;
    assign tmo_hit = ~filt_r[SYN_SCL] && tmo_r == TW'(TMO_CYC - 1);

    always_comb
    begin
        if (filt_r[SYN_SCL])
            tmo_nxt = '0;
        else if (tmo_hit)
            tmo_nxt = tmo_r;
        else
            tmo_nxt = tmo_r + TW'(1);
    end

    // Byte engine
    always_comb
    begin
        st_nxt = st_r;
        bit_nxt = bit_r;
        sh_nxt = sh_r;
        cmd_nxt = cmd_r;
        wd_nxt = wd_r;
        ph_nxt = ph_r;
        rw_nxt = rw_r;
        oe_nxt = oe_r;
        ack_nxt = ack_r;
        stb_nxt = 1'b0;
        rdq_nxt = 1'b0;
        if (tmo_hit || stop_c)
        begin
            st_nxt = S_IDLE;
            oe_nxt = 1'b0;
        end
        else if (start_c)
        begin
            st_nxt = S_RX;
            ph_nxt = PH_ADDR;
            bit_nxt = 3'h0;
            oe_nxt = 1'b0;
        end
        else
        begin
            case (st_r)
                S_RX:
                    if (scl_rise)
                    begin
                        sh_nxt = {sh_r[6:0], filt_r[SYN_SDA]};
                        bit_nxt = bit_r + 3'h1;
                        if (bit_r == 3'h7)
                            st_nxt = S_RXD;
                    end
                S_RXD:
                    if (scl_fall)
                    begin
                        st_nxt = S_ACK;
                        ack_nxt = 1'b0;
                        if (ph_r == PH_ADDR)
                        begin
                            // Fixed strap address only
                            if (strap.addr_valid &&
                                sh_r[7:1] == strap.tgt_addr)
                            begin
                                ack_nxt = 1'b1;
                                rw_nxt = sh_r[0];
                                rdq_nxt = sh_r[0];
                                ph_nxt = PH_CMD;
                            end
                        end
                        else if (ph_r == PH_CMD)
                        begin
                            ack_nxt = 1'b1;
                            cmd_nxt = sh_r;
                            ph_nxt = PH_DATA;
                        end
                        else if (write_ok)
                        begin
                            ack_nxt = 1'b1;
                            stb_nxt = 1'b1;
                            wd_nxt = sh_r;
                        end
                        oe_nxt = ack_nxt;
                    end
                S_ACK:
                    if (scl_fall)
                    begin
                        oe_nxt = 1'b0;
                        bit_nxt = 3'h0;
                        if (!ack_r)
                            st_nxt = S_IDLE;
                        else if (rw_r)
                        begin
                            st_nxt = S_TX;
                            sh_nxt = rd_data;
                            oe_nxt = ~rd_data[7];
                        end
                        else
                            st_nxt = S_RX;
                    end
                S_TX:
                    if (scl_rise)
                    begin
                        sh_nxt = {sh_r[6:0], 1'b0};
                        bit_nxt = bit_r + 3'h1;
                        if (bit_r == 3'h7)
                            st_nxt = S_TXD;
                    end
                    else if (scl_fall)
                        oe_nxt = ~sh_r[7];
                S_TXD:
                    if (scl_fall)
                    begin
                        oe_nxt = 1'b0;
                        st_nxt = S_MACK;
                    end
                S_MACK:
                    if (scl_rise)
                    begin
                        if (!filt_r[SYN_SDA])
                        begin
                            rdq_nxt = 1'b1;
                            st_nxt = S_TXL;
                        end
                        else
                            st_nxt = S_IDLE;
                    end
                S_TXL:
                    if (scl_fall)
                    begin
                        st_nxt = S_TX;
                        bit_nxt = 3'h0;
                        sh_nxt = rd_data;
                        oe_nxt = ~rd_data[7];
                    end
                default:
                    st_nxt = S_IDLE;
            endcase
        end
    end

    always_ff @(posedge mclk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            tmo_r <= '0;
            st_r <= S_IDLE;
            bit_r <= 3'h0;
            sh_r <= 8'h00;
            cmd_r <= 8'h00;
            wd_r <= 8'h00;
            ph_r <= PH_ADDR;
            rw_r <= 1'b0;
            oe_r <= 1'b0;
            ack_r <= 1'b0;
            stb_r <= 1'b0;
            rdq_r <= 1'b0;
        end
        else
        begin
            tmo_r <= tmo_nxt;
            st_r <= st_nxt;
            bit_r <= bit_nxt;
            sh_r <= sh_nxt;
            cmd_r <= cmd_nxt;
            wd_r <= wd_nxt;
            ph_r <= ph_nxt;
            rw_r <= rw_nxt;
            oe_r <= oe_nxt;
            ack_r <= ack_nxt;
            stb_r <= stb_nxt;
            rdq_r <= rdq_nxt;
        end
    end

    // Open-drain data pin; no alert output exists
    assign sda_o = 1'b0;
    assign sda_oe = oe_r;
    assign tgt_addr = strap.tgt_addr;
    assign addr_valid = strap.addr_valid;
    assign cmd_code = cmd_r;
    assign wr_data = wd_r;
    assign wr_stb = stb_r;
    assign rd_req = rdq_r;
    assign bus_busy = st_r != S_IDLE;

    a_foreign_addr_nack: assert property (
        st_r == S_RXD && scl_fall && ph_r == PH_ADDR && !tmo_hit &&
        !stop_c && !start_c && sh_r[7:1] != strap.tgt_addr
        |=> !sda_oe ##1 st_r == S_ACK && !ack_r)
        else $error("Foreign address was acknowledged");
    a_op_bias_gate: assert property (
        wr_stb && cmd_code == CMD_OPERATION |-> $past(bias))
        else $error("OPERATION write accepted without bias");
    a_limit_write_gate: assert property (
        wr_stb && is_limit_cmd(cmd_code) |->
        $past(bias) && $past(filt_r[SYN_DIS]) &&
        $past(filt_r[SYN_UVLO]))
        else $error("Limit write accepted outside permitted state");
    a_rejected_write_nack: assert property (
        st_r == S_RXD && scl_fall && ph_r == PH_DATA && !write_ok &&
        !tmo_hit && !stop_c && !start_c
        |=> !wr_stb && !sda_oe)
        else $error("Rejected write was acknowledged");
    a_read_answered: assert property (
        st_r == S_RXD && scl_fall && ph_r == PH_ADDR && !tmo_hit &&
        !stop_c && !start_c && strap.addr_valid &&
        sh_r == {strap.tgt_addr, 1'b1}
        |=> rd_req && sda_oe)
        else $error("Read address not answered");
    a_timeout_idle: assert property (
        tmo_hit |=> st_r == S_IDLE && !sda_oe && !bus_busy)
        else $error("Clock-low timeout did not idle interface");
    a_stop_releases: assert property (
        stop_c && !tmo_hit |=> !sda_oe && st_r == S_IDLE)
        else $error("Stop did not release the bus");
    a_strobe_one_cycle: assert property (
        wr_stb |=> !wr_stb)
        else $error("Write strobe longer than one cycle");
endmodule

// ==== pkg/pmbaf_pkg.sv ====
// Shared constants, types and helpers of the strap-address bus front end
package pmbaf_pkg;
    localparam int unsigned CLK_HZ = 10_000_000;
    localparam int unsigned CYC_PER_US = CLK_HZ / 1_000_000;
    // Strap registration time after startup, in microseconds
    localparam int unsigned ADDR_REG_US = 1000;
    localparam int unsigned ADDR_REG_CYC = ADDR_REG_US * CYC_PER_US;
    // Clock-low timeout, lower bound, in microseconds
    localparam int unsigned TIMEOUT_US = 25000;
    localparam int unsigned TIMEOUT_CYC = TIMEOUT_US * CYC_PER_US;
    // Strap level coding: millivolts, 0 to 3300, sixteen bands
    localparam int unsigned LEVEL_W = 12;
    localparam int unsigned ADDR_SPAN_MV = 3300;
    localparam int unsigned NUM_BANDS = 16;
    localparam int unsigned BAND_UV = 206250;
    // Base target address; arbitrary value
    localparam logic [6:0] TGT_BASE_DEF = 7'h20;
    // Command codes
    localparam logic [7:0] CMD_OPERATION = 8'h01;
    localparam logic [7:0] CMD_OT_FAULT = 8'h4f;
    localparam logic [7:0] CMD_OT_WARN = 8'h51;
    localparam logic [7:0] CMD_VIN_OV_FAULT = 8'h55;
    localparam logic [7:0] CMD_VIN_OV_WARN = 8'h57;
    localparam logic [7:0] CMD_IIN_OC_FAULT = 8'h5b;
    localparam logic [7:0] CMD_IIN_OC_WARN = 8'h5d;
    localparam logic [7:0] CMD_TON_DELAY = 8'h60;
    localparam logic [7:0] CMD_DIS_FAULTS = 8'hd7;
    // Synchroniser lanes and their idle values
    localparam int unsigned SYN_N = 5;
    localparam int unsigned SYN_SCL = 0;
    localparam int unsigned SYN_SDA = 1;
    localparam int unsigned SYN_BIAS = 2;
    localparam int unsigned SYN_DIS = 3;
    localparam int unsigned SYN_UVLO = 4;
    localparam logic [4:0] SYN_RST = 5'h03;
    // Byte phases of a transfer
    localparam logic [1:0] PH_ADDR = 2'h0;
    localparam logic [1:0] PH_CMD = 2'h1;
    localparam logic [1:0] PH_DATA = 2'h2;

    typedef enum logic [2:0] {
        S_IDLE = 3'b000,
        S_RX = 3'b001,
        S_RXD = 3'b010,
        S_ACK = 3'b011,
        S_TX = 3'b100,
        S_TXD = 3'b101,
        S_MACK = 3'b110,
        S_TXL = 3'b111
    } pmbaf_state_e;

    function automatic logic is_limit_cmd(input logic [7:0] c);
        return c == CMD_OT_FAULT || c == CMD_OT_WARN ||
            c == CMD_VIN_OV_FAULT || c == CMD_VIN_OV_WARN ||
            c == CMD_IIN_OC_FAULT || c == CMD_IIN_OC_WARN ||
            c == CMD_TON_DELAY || c == CMD_DIS_FAULTS;
    endfunction

    function automatic logic [3:0] band_of(input logic [LEVEL_W-1:0] mv);
        logic [3:0] b;
        logic [31:0] uv;
        b = 4'h0;
        uv = 32'(mv) * 32'd1000;
        for (int unsigned i = 1; i < NUM_BANDS; i++)
        begin
            if (uv >= i * BAND_UV)
                b = 4'(i);
        end
        return b;
    endfunction
endpackage

// ==== pkg/pmbaf_strap_if.sv ====
// Carrier for the latched target address
`timescale 1ns/1ps
interface pmbaf_strap_if;
    logic [6:0] tgt_addr;
    logic addr_valid;
    modport src (output tgt_addr, output addr_valid);
    modport snk (input tgt_addr, input addr_valid);
endinterface

// ==== rtl/pmbaf_strap_latch.sv ====
// Startup sampling and latching of the strapped target address
`timescale 1ns/1ps
module pmbaf_strap_latch
    import pmbaf_pkg::*;
#(
    parameter int unsigned REG_CYC = ADDR_REG_CYC,
    parameter logic [6:0] TGT_BASE = TGT_BASE_DEF
)(
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic [LEVEL_W-1:0] addr_level_mv,
    pmbaf_strap_if.src sp
);
    localparam int unsigned CW = $clog2(REG_CYC + 1);
    logic [CW-1:0] cnt_r, cnt_nxt;
    logic lat_r, lat_nxt;
    logic [6:0] addr_r, addr_nxt;

    always_comb
    begin
        cnt_nxt = cnt_r;
        lat_nxt = lat_r;
        addr_nxt = addr_r;
        if (!lat_r)
        begin
            // Sample once at the end of registration time, then freeze
            if (cnt_r == CW'(REG_CYC - 1))
            begin
                lat_nxt = 1'b1;
                addr_nxt = TGT_BASE + {3'h0, band_of(addr_level_mv)};
            end
            else
                cnt_nxt = cnt_r + CW'(1);
        end
    end

    always_ff @(posedge mclk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            cnt_r <= '0;
            lat_r <= 1'b0;
            addr_r <= 7'h00;
        end
        else
        begin
            cnt_r <= cnt_nxt;
            lat_r <= lat_nxt;
            addr_r <= addr_nxt;
        end
    end

    assign sp.tgt_addr = addr_r;
    assign sp.addr_valid = lat_r;

    a_addr_held_stable: assert property (@(posedge mclk) disable iff (sys_rst)
        lat_r |=> lat_r && $stable(addr_r))
        else $error("Latched address changed after startup");
    a_addr_band_map: assert property (@(posedge mclk) disable iff (sys_rst)
        $rose(lat_r) |->
        addr_r == TGT_BASE + {3'h0, band_of($past(addr_level_mv))})
        else $error("Latched address does not match strap band");
endmodule

// ==== test/pmbaf_host_model.sv ====
// Behavioural two-wire host controller for the front end
`timescale 1ns/1ps
module pmbaf_host_model #(
    parameter int H = 8
)(
    input wire logic mclk,
    input wire logic sda_in,
    output logic scl,
    output logic sda_drv
);
    initial
    begin
        scl = 1'b1;
        sda_drv = 1'b1;
    end

    task automatic hw(input int n);
        repeat (n) @(posedge mclk);
        #10;
    endtask

    // Data changes only while the clock is low
    task automatic bit_x(input logic b, output logic r);
        sda_drv = b;
        hw(H);
        scl = 1'b1;
        hw(H);
        r = sda_in;
        hw(H);
        scl = 1'b0;
        hw(H);
    endtask

    // Start or repeated start
    task automatic go_start;
        sda_drv = 1'b1;
        hw(H);
        scl = 1'b1;
        hw(H);
        sda_drv = 1'b0;
        hw(H);
        scl = 1'b0;
        hw(H);
    endtask

    task automatic go_stop;
        sda_drv = 1'b0;
        hw(H);
        scl = 1'b1;
        hw(H);
        sda_drv = 1'b1;
        hw(H);
    endtask

    task automatic wr_byte(input logic [7:0] d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--)
            bit_x(d[i], r);
        bit_x(1'b1, r);
        ack = ~r;
    endtask

    // Status is learnt only by polling reads
    task automatic rd_byte(input logic mack, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--)
        begin
            bit_x(1'b1, r);
            d[i] = r;
        end
        bit_x(~mack, r);
    endtask
endmodule

// ==== test/tb_pmbus_addr_strap_frontend.sv ====
// Self-checking bench of the strap-address bus front end
`timescale 1ns/1ps
module tb_pmbus_addr_strap_frontend;
    import pmbaf_pkg::*;
    localparam int TMO = 200;
    localparam int RCYC = 16;
    logic mclk, sys_rst, scl, hsda, sda, sda_o, sda_oe;
    logic bias, dis, uvlo, addr_valid, wr_stb, rd_req, bus_busy;
    logic [LEVEL_W-1:0] lvl;
    logic [6:0] tgt_addr;
    logic [7:0] cmd_code, wr_data, rd_data, last_wd, last_cmd;
    int err_total, checks_done, stb_n;
    logic [7:0] cmds [10] = '{8'h01, 8'h4f, 8'h51, 8'h55, 8'h57,
        8'h5b, 8'h5d, 8'h60, 8'hd7, 8'h03};
    int corner [6] = '{0, 206, 207, 3093, 3094, 3300};

    assign sda = hsda & ~sda_oe;

    pmbaf_frontend #(.TMO_CYC(TMO), .REG_CYC(RCYC)) uut (
        .mclk(mclk), .sys_rst(sys_rst), .scl_i(scl), .sda_i(sda),
        .sda_o(sda_o), .sda_oe(sda_oe), .aux_bias_supply(bias),
        .module_disabled(dis), .hi_below_uvlo(uvlo),
        .addr_level_mv(lvl), .tgt_addr(tgt_addr),
        .addr_valid(addr_valid), .cmd_code(cmd_code),
        .wr_data(wr_data), .wr_stb(wr_stb), .rd_req(rd_req),
        .rd_data(rd_data), .bus_busy(bus_busy)
    );

    pmbaf_host_model host (
        .mclk(mclk), .sda_in(sda), .scl(scl), .sda_drv(hsda)
    );

    initial
    begin
        mclk = 1'b0;
        forever #50 mclk = ~mclk;
    end

    always @(posedge mclk)
    begin
        if (wr_stb === 1'b1)
        begin
            stb_n <= stb_n + 1;
            last_wd <= wr_data;
            last_cmd <= cmd_code;
        end
        if (rd_req === 1'b1)
            rd_data <= rd_data + 8'h35;
    end

    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            err_total++;
            $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic test_done;
        $display("checks=%0d mismatches=%0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    function automatic logic [6:0] exp_addr(input int mv);
        int b;
        b = (mv * 1000) / 206250;
        if (b > 15)
            b = 15;
        return TGT_BASE_DEF + 7'(b);
    endfunction

    // Index 0 is the enable command, 1..8 limits, 9 unguarded
    function automatic logic exp_ok(input int k, input logic [2:0] c);
        if (k == 0)
            return c[2];
        if (k < 9)
            return &c;
        return 1'b1;
    endfunction

    task automatic tick(input int n);
        repeat (n) @(posedge mclk);
        #10;
    endtask

    task automatic do_reset(input int mv);
        lvl = 12'(mv);
        sys_rst = 1'b1;
        tick(6);
        sys_rst = 1'b0;
        tick(RCYC + 4);
    endtask

    task automatic wr_xfer(input logic [6:0] a, input logic [7:0] c,
        input logic [7:0] d, output logic [2:0] acks);
        host.go_start();
        host.wr_byte({a, 1'b0}, acks[2]);
        host.wr_byte(c, acks[1]);
        host.wr_byte(d, acks[0]);
        host.go_stop();
        tick(4);
    endtask

    initial
    begin
        repeat (90000) @(posedge mclk);
        err_total++;
        test_done();
    end

    initial
    begin
        logic [2:0] ak, cnd;
        logic [7:0] d, rb, r0;
        logic [6:0] ta;
        logic a, dirty;
        int n0, mv;
        sys_rst = 1'b1;
        lvl = '0;
        {bias, dis, uvlo} = 3'h0;
        rd_data = 8'h5a;
        stb_n = 0;
        err_total = 0;
        checks_done = 0;
        dirty = 1'b0;
        mv = $urandom(45);
        for (int i = 0; i < 7; i++)
        begin
            mv = (i < 6) ? corner[i] : $urandom_range(3300);
            do_reset(mv);
            ta = exp_addr(mv);
            chk(8'(addr_valid), 8'h01);
            chk(8'(tgt_addr), 8'(ta));
            lvl = 12'($urandom_range(3300));
            tick(20);
            chk(8'(tgt_addr), 8'(ta));
        end
        $display("strap tests done");
        host.go_start();
        host.wr_byte({ta ^ 7'h01, 1'b0}, a);
        host.go_stop();
        chk(8'(a), 8'h00);
        $display("foreign address test done");
        for (int k = 0; k < 10; k++)
            for (int t = 0; t < 3; t++)
            begin
                // Once a limit changed, stay disabled until commit
                cnd = (t == 2) ? 3'h7 : (k == 1 && t == 0) ? 3'h5 :
                    (3'($urandom) | (dirty ? 3'h2 : 3'h0));
                {bias, dis, uvlo} = cnd;
                d = 8'($urandom);
                n0 = stb_n;
                tick(6);
                wr_xfer(ta, cmds[k], d, ak);
                chk(8'(ak[2:1]), 8'h03);
                if (k > 0 && k < 9 && exp_ok(k, cnd))
                    dirty = 1'b1;
                chk(8'(ak[0]), 8'(exp_ok(k, cnd)));
                chk(8'(stb_n - n0), 8'(exp_ok(k, cnd)));
                if (exp_ok(k, cnd))
                begin
                    chk(last_wd, d);
                    chk(last_cmd, cmds[k]);
                end
            end
        // Stay disabled while the limit change is committed
        dis = 1'b1;
        tick(30000);
        $display("write gating tests done");
        {bias, dis, uvlo} = 3'h1;
        tick(6);
        r0 = rd_data;
        host.go_start();
        host.wr_byte({ta, 1'b0}, a);
        host.wr_byte(8'h8b, a);
        host.go_start();
        host.wr_byte({ta, 1'b1}, a);
        chk(8'(a), 8'h01);
        for (int j = 0; j < 3; j++)
        begin
            host.rd_byte(j < 2, rb);
            chk(rb, r0 + 8'(8'h35 * (j + 1)));
        end
        host.go_stop();
        $display("read without bias test done");
        host.go_start();
        host.wr_byte({ta, 1'b0}, a);
        chk(8'(bus_busy), 8'h01);
        tick(TMO + 20);
        chk(8'({bus_busy, sda_oe}), 8'h00);
        chk(8'(sda_o), 8'h00);
        host.go_stop();
        $display("clock low timeout test done");
        test_done();
    end
endmodule
